// File: rtl/asq_scan_queue.sv
// Scan queue, input selection and error flags of the converter, APB slave
//
// Notes on behaviour
// R01: Sixteen entries convert in sequence autonomously.
// R02: One scan per trigger, or continuous repeat.
// R03: Entry n uses selection register n.
// R04: Mask request bit n enables entry n.
// R05: Software writes entry selects only while disabled.
// R06: Mask request held until queue stops scanning.
// R07: Pending flag set until mask transferred.
// R08: Running scan keeps its starting working mask.
// R09: Software waits pending clear before rewriting mask.
// R10: Five reference sources, bandgap after reset.
// R11: Gain choice 0.5x to 4x per set.
// R12: Software keeps conversion clock within gain limit.
// R13: Selection field picks one of two sets.
// R14: Single queue has own same-layout select.
// R15: Port and pin fields pick both inputs.
// R16: Unallocated bus sets flag, result zero.
// R17: Invalid input pairing raises polarity error.
// R18: Single-ended result is unsigned.
// R19: Ground negative port ignores negative pin.
// R20: Differential result is two's complement signed.
// R21: Entries visited ascending, masked ones skipped.
`timescale 1ns/1ps
`default_nettype none
module asq_scan_queue (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  output logic conv_start,
  output logic [3:0] conv_pos_port,
  output logic [3:0] conv_pos_pin,
  output logic [3:0] conv_neg_port,
  output logic [3:0] conv_neg_pin,
  output logic [2:0] conv_reference,
  output logic [2:0] conv_gain,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  // Results
  output logic result_valid,
  output logic [11:0] result_data,
  output logic [3:0] result_entry,
  output logic result_single
);
  import asq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // First enabled entry at or above from; bit 4 set when none left
  function automatic logic [4:0] next_entry(input logic [15:0] m, input logic [4:0] from);
    logic [4:0] r;
    r = 5'h10;
    for (int i = ASQ_ENTRIES - 1; i >= 0; i--)
    begin
      if (m[i] && (5'(i) >= from))
        r = 5'(i); // [R21]
    end
    return r;
  endfunction : next_entry

  // Alloc table holds an even and an odd bus bit per GPIO port
  function automatic logic alloc_miss(input logic [3:0] port, input logic [3:0] pin,
                                      input logic [7:0] alloc);
    logic [2:0] idx;
    idx = {port[1:0], pin[0]};
    return (port[3] && !alloc[idx]);
  endfunction : alloc_miss

  ////////////////////////////////////////////////////////////////////////////
  // State

  asq_state_t state_q, state_d;
  logic enable_q, enable_d, cont_q, cont_d;
  logic scan_req_q, scan_req_d, single_req_q, single_req_d;
  logic scanning_q, scanning_d, is_single_q, is_single_d;
  logic pending_q, pending_d, alloc_err_q, alloc_err_d, pol_err_q, pol_err_d;
  logic diff_q, diff_d;
  logic [3:0] entry_q, entry_d;
  logic [15:0] mask_req_q, mask_req_d, mask_work_q, mask_work_d;
  logic [7:0] alloc_q, alloc_d;
  logic [6:0] cfg_q [2], cfg_d [2];
  logic [16:0] single_sel_q, single_sel_d;
  logic [16:0] scan_sel_q [ASQ_ENTRIES], scan_sel_d [ASQ_ENTRIES];
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic conv_start_q, conv_start_d;
  logic [3:0] pos_port_q, pos_port_d, pos_pin_q, pos_pin_d;
  logic [3:0] neg_port_q, neg_port_d, neg_pin_q, neg_pin_d;
  logic [2:0] ref_q, ref_d, gain_q, gain_d;
  logic res_valid_q, res_valid_d, res_single_q, res_single_d;
  logic [11:0] res_data_q, res_data_d;
  logic [3:0] res_entry_q, res_entry_d;
  // Combinational scratch
  logic wr, hit, scan_hit, neg_gnd, pos_gnd, same_mux, a_err, p_err;
  logic [16:0] sel;
  logic [6:0] cset;
  logic [4:0] nxt;
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus side first, queue after, so hardware sets win; mask pending and disable come last

  always_comb
  begin
    state_d = state_q;
    enable_d = enable_q;
    cont_d = cont_q;
    scan_req_d = scan_req_q;
    single_req_d = single_req_q;
    scanning_d = scanning_q;
    is_single_d = is_single_q;
    pending_d = pending_q;
    alloc_err_d = alloc_err_q;
    pol_err_d = pol_err_q;
    diff_d = diff_q;
    entry_d = entry_q;
    mask_req_d = mask_req_q;
    mask_work_d = mask_work_q;
    alloc_d = alloc_q;
    cfg_d = cfg_q;
    single_sel_d = single_sel_q;
    scan_sel_d = scan_sel_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    conv_start_d = 1'b0;
    pos_port_d = pos_port_q;
    pos_pin_d = pos_pin_q;
    neg_port_d = neg_port_q;
    neg_pin_d = neg_pin_q;
    ref_d = ref_q;
    gain_d = gain_q;
    res_valid_d = 1'b0;
    res_single_d = res_single_q;
    res_data_d = res_data_q;
    res_entry_d = res_entry_q;
    sel = ASQ_SEL_RESET;
    cset = cfg_q[0];
    nxt = 5'h10;
    scan_hit = (paddr[11:6] == ASQ_SCAN_PAGE);
    hit = 1'b1;
    rd = 32'h00000000;

    // Read decode, one wait state keeps every bus output registered
    case (paddr)
      ASQ_OFS_CTRL: rd = {30'h0, cont_q, enable_q};
      ASQ_OFS_STATUS: rd = {20'h0, entry_q, 4'h0, pol_err_q, alloc_err_q, scanning_q,
                            pending_q}; // [R07]
      ASQ_OFS_MASK_REQ: rd = {16'h0, mask_req_q};
      ASQ_OFS_MASK_WORK: rd = {16'h0, mask_work_q};
      ASQ_OFS_CFG0: rd = {25'h0, cfg_q[0]};
      ASQ_OFS_CFG1: rd = {25'h0, cfg_q[1]};
      ASQ_OFS_SINGLE: rd = {15'h0, single_sel_q};
      ASQ_OFS_BUS_ALLOC: rd = {24'h0, alloc_q};
      ASQ_OFS_RESULT: rd = {7'h0, res_single_q, 4'h0, res_entry_q, 4'h0, res_data_q};
      default:
      begin
        hit = scan_hit && (paddr[1:0] == 2'b00);
        rd = hit ? {15'h0, scan_sel_q[paddr[5:2]]} : 32'h00000000;
      end
    endcase
    if (psel && penable && !pready_q)
    begin
      pready_d = 1'b1;
      prdata_d = rd;
      pslverr_d = !hit;
    end

    // Writes take effect at the completing edge
    wr = psel && penable && pready_q && pwrite && !pslverr_q;
    if (wr)
    begin
      case (paddr)
        ASQ_OFS_CTRL:
        begin
          enable_d = pwdata[ASQ_CTRL_ENABLE];
          cont_d = pwdata[ASQ_CTRL_CONT];
          scan_req_d = scan_req_q | pwdata[ASQ_CTRL_SCAN_GO];
          single_req_d = single_req_q | pwdata[ASQ_CTRL_SINGLE_GO];
        end
        ASQ_OFS_STATUS:
        begin
          // Write one to clear; a same-cycle error below still sets
          if (pwdata[ASQ_ST_ALLOC_ERR])
            alloc_err_d = 1'b0;
          if (pwdata[ASQ_ST_POL_ERR])
            pol_err_d = 1'b0;
        end
        ASQ_OFS_MASK_REQ:
        begin
          mask_req_d = pwdata[15:0]; // [R04]
        end
        ASQ_OFS_CFG0, ASQ_OFS_CFG1:
        begin
          // Unused reference codes fall back to the bandgap
          if (!enable_q)
          begin
            cfg_d[paddr[2]] = {pwdata[6:4], 1'b0,
                               (pwdata[2:0] > ASQ_REF_VDD_BUF) ? ASQ_REF_BANDGAP : pwdata[2:0]}; // [R10] [R11]
          end
        end
        ASQ_OFS_SINGLE:
        begin
          if (!enable_q)
            single_sel_d = pwdata[16:0]; // [R14]
        end
        ASQ_OFS_BUS_ALLOC: alloc_d = pwdata[7:0];
        default:
        begin
          // Entry selects are frozen while enabled to protect a live scan
          if (scan_hit && !enable_q)
            scan_sel_d[paddr[5:2]] = pwdata[16:0]; // [R03] [R05]
        end
      endcase
    end

    // Selection for the conversion under way
    sel = is_single_q ? single_sel_q : scan_sel_q[entry_q]; // [R03] [R14]
    cset = cfg_q[sel[ASQ_SEL_CFG_BIT]]; // [R13]
    pos_gnd = (sel[15:12] == ASQ_PORT_GND);
    neg_gnd = (sel[7:4] == ASQ_PORT_GND); // [R19]
    // Even mux: even pins and supplies; odd mux: odd pins
    same_mux = ((sel[15] ? sel[8] : 1'b0) == (sel[7] ? sel[0] : 1'b0));
    p_err = !pos_gnd && !neg_gnd && same_mux; // [R17]
    a_err = alloc_miss(sel[15:12], sel[11:8], alloc_q) ||
            (!neg_gnd && alloc_miss(sel[7:4], sel[3:0], alloc_q)); // [R16]

    // Queue sequencer
    case (state_q)
      ASQ_IDLE:
      begin
        if (pending_q)
        begin
          mask_work_d = mask_req_q; // [R06]
          pending_d = 1'b0;
        end
        else if (enable_q && single_req_q)
        begin
          single_req_d = 1'b0;
          is_single_d = 1'b1;
          state_d = ASQ_ISSUE;
        end
        else if (enable_q && (scan_req_q || cont_q))
        begin
          scan_req_d = 1'b0; // [R02]
          nxt = next_entry(mask_work_q, 5'h00);
          if (!nxt[4])
          begin
            entry_d = nxt[3:0];
            is_single_d = 1'b0;
            scanning_d = 1'b1;
            state_d = ASQ_ISSUE;
          end
        end
      end
      ASQ_ISSUE:
      begin
        res_single_d = is_single_q;
        res_entry_d = entry_q;
        diff_d = !neg_gnd;
        if (a_err || p_err)
        begin
          // Build on the bus result so a same-cycle clear of the other flag holds
          alloc_err_d = alloc_err_d | a_err; // [R16]
          pol_err_d = pol_err_d | p_err; // [R17]
          res_data_d = 12'h000; // [R16]
          res_valid_d = 1'b1;
          state_d = ASQ_NEXT;
        end
        else
        begin
          pos_port_d = sel[15:12]; // [R15]
          pos_pin_d = sel[11:8];
          neg_port_d = sel[7:4];
          neg_pin_d = neg_gnd ? 4'h0 : sel[3:0]; // [R19]
          ref_d = cset[2:0]; // [R10]
          gain_d = cset[6:4]; // [R11]
          conv_start_d = 1'b1;
          state_d = ASQ_WAIT;
        end
      end
      ASQ_WAIT:
      begin
        if (conv_done)
        begin
          // Core code is offset binary; flip the top bit for signed form
          res_data_d = diff_q ? (conv_data ^ ASQ_DIFF_FLIP) : conv_data; // [R18] [R20]
          res_valid_d = 1'b1;
          state_d = ASQ_NEXT;
        end
      end
      ASQ_NEXT:
      begin
        nxt = next_entry(mask_work_q, {1'b0, entry_q} + 5'h01); // [R01] [R08] [R21]
        if (!is_single_q && !nxt[4])
        begin
          entry_d = nxt[3:0];
          state_d = ASQ_ISSUE;
        end
        else
        begin
          scanning_d = 1'b0;
          state_d = ASQ_IDLE;
        end
      end
      default: state_d = ASQ_IDLE;
    endcase

    // Mask writes go pending; a write wins over the transfer above
    if (wr && (paddr == ASQ_OFS_MASK_REQ))
      pending_d = 1'b1; // [R06] [R07]

    // Disabling drops the queue back to idle
    if (!enable_q)
    begin
      state_d = ASQ_IDLE;
      scanning_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ASQ_IDLE;
      enable_q <= 1'b0;
      cont_q <= 1'b0;
      scan_req_q <= 1'b0;
      single_req_q <= 1'b0;
      scanning_q <= 1'b0;
      is_single_q <= 1'b0;
      pending_q <= 1'b0;
      alloc_err_q <= 1'b0;
      pol_err_q <= 1'b0;
      diff_q <= 1'b0;
      entry_q <= 4'h0;
      mask_req_q <= ASQ_MASK_RESET;
      mask_work_q <= ASQ_MASK_RESET;
      alloc_q <= ASQ_ALLOC_RESET;
      cfg_q[0] <= {ASQ_GAIN_1X, 1'b0, ASQ_REF_BANDGAP}; // [R10]
      cfg_q[1] <= {ASQ_GAIN_1X, 1'b0, ASQ_REF_BANDGAP};
      single_sel_q <= ASQ_SEL_RESET;
      for (int i = 0; i < ASQ_ENTRIES; i++)
        scan_sel_q[i] <= ASQ_SEL_RESET;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      conv_start_q <= 1'b0;
      pos_port_q <= ASQ_PORT_GND;
      pos_pin_q <= 4'h0;
      neg_port_q <= ASQ_PORT_GND;
      neg_pin_q <= 4'h0;
      ref_q <= ASQ_REF_BANDGAP;
      gain_q <= ASQ_GAIN_1X;
      res_valid_q <= 1'b0;
      res_single_q <= 1'b0;
      res_data_q <= 12'h000;
      res_entry_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      enable_q <= enable_d;
      cont_q <= cont_d;
      scan_req_q <= scan_req_d;
      single_req_q <= single_req_d;
      scanning_q <= scanning_d;
      is_single_q <= is_single_d;
      pending_q <= pending_d;
      alloc_err_q <= alloc_err_d;
      pol_err_q <= pol_err_d;
      diff_q <= diff_d;
      entry_q <= entry_d;
      mask_req_q <= mask_req_d;
      mask_work_q <= mask_work_d;
      alloc_q <= alloc_d;
      cfg_q <= cfg_d;
      single_sel_q <= single_sel_d;
      scan_sel_q <= scan_sel_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      conv_start_q <= conv_start_d;
      pos_port_q <= pos_port_d;
      pos_pin_q <= pos_pin_d;
      neg_port_q <= neg_port_d;
      neg_pin_q <= neg_pin_d;
      ref_q <= ref_d;
      gain_q <= gain_d;
      res_valid_q <= res_valid_d;
      res_single_q <= res_single_d;
      res_data_q <= res_data_d;
      res_entry_q <= res_entry_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_start = conv_start_q;
  assign conv_pos_port = pos_port_q;
  assign conv_pos_pin = pos_pin_q;
  assign conv_neg_port = neg_port_q;
  assign conv_neg_pin = neg_pin_q;
  assign conv_reference = ref_q;
  assign conv_gain = gain_q;
  assign result_valid = res_valid_q;
  assign result_data = res_data_q;
  assign result_entry = res_entry_q;
  assign result_single = res_single_q;
endmodule : asq_scan_queue
`default_nettype wire

// File: rtl/asq_pkg.sv
// Constants for the converter scan queue and input select block
package asq_pkg;
  localparam int ASQ_ENTRIES = 16;
  localparam int ASQ_RES_BITS = 12;
  // Register byte offsets
  localparam logic [11:0] ASQ_OFS_CTRL = 12'h000;
  localparam logic [11:0] ASQ_OFS_STATUS = 12'h004;
  localparam logic [11:0] ASQ_OFS_MASK_REQ = 12'h008;
  localparam logic [11:0] ASQ_OFS_MASK_WORK = 12'h00c;
  localparam logic [11:0] ASQ_OFS_CFG0 = 12'h010;
  localparam logic [11:0] ASQ_OFS_CFG1 = 12'h014;
  localparam logic [11:0] ASQ_OFS_SINGLE = 12'h018;
  localparam logic [11:0] ASQ_OFS_BUS_ALLOC = 12'h01c;
  localparam logic [11:0] ASQ_OFS_RESULT = 12'h020;
  localparam logic [5:0] ASQ_SCAN_PAGE = 6'h01;
  // Control register bits
  localparam int ASQ_CTRL_ENABLE = 0;
  localparam int ASQ_CTRL_CONT = 1;
  localparam int ASQ_CTRL_SCAN_GO = 4;
  localparam int ASQ_CTRL_SINGLE_GO = 5;
  // Status register bits
  localparam int ASQ_ST_PENDING = 0;
  localparam int ASQ_ST_SCANNING = 1;
  localparam int ASQ_ST_ALLOC_ERR = 2;
  localparam int ASQ_ST_POL_ERR = 3;
  localparam int ASQ_ST_ENTRY_LSB = 8;
  // Selection register layout, common to single and scan entries
  localparam int ASQ_SEL_NEG_PIN_LSB = 0;
  localparam int ASQ_SEL_NEG_PORT_LSB = 4;
  localparam int ASQ_SEL_POS_PIN_LSB = 8;
  localparam int ASQ_SEL_POS_PORT_LSB = 12;
  localparam int ASQ_SEL_CFG_BIT = 16;
  localparam int ASQ_SEL_W = 17;
  localparam logic [16:0] ASQ_SEL_RESET = 17'h00000;
  // Configuration set layout
  localparam int ASQ_CFG_REF_LSB = 0;
  localparam int ASQ_CFG_GAIN_LSB = 4;
  localparam logic [2:0] ASQ_REF_BANDGAP = 3'h0;
  localparam logic [2:0] ASQ_REF_EXT = 3'h1;
  localparam logic [2:0] ASQ_REF_EXT2 = 3'h2;
  localparam logic [2:0] ASQ_REF_VDD = 3'h3;
  localparam logic [2:0] ASQ_REF_VDD_BUF = 3'h4;
  localparam logic [2:0] ASQ_GAIN_HALF = 3'h0;
  localparam logic [2:0] ASQ_GAIN_1X = 3'h1;
  localparam logic [2:0] ASQ_GAIN_4X = 3'h4;
  // Port codes
  localparam logic [3:0] ASQ_PORT_GND = 4'h0;
  localparam logic [3:0] ASQ_PORT_SUPPLY = 4'h1;
  localparam logic [3:0] ASQ_PORT_GPIO_A = 4'h8;
  localparam logic [11:0] ASQ_DIFF_FLIP = 12'h800;
  localparam logic [7:0] ASQ_ALLOC_RESET = 8'h00;
  localparam logic [15:0] ASQ_MASK_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ASQ_IDLE = 2'b00,
    ASQ_ISSUE = 2'b01,
    ASQ_WAIT = 2'b11,
    ASQ_NEXT = 2'b10
  } asq_state_t;
endpackage : asq_pkg

// File: dv/asq_scan_queue_monitor.sv
// Port checker for the converter scan queue block
`timescale 1ns/1ps
`default_nettype none
module asq_scan_queue_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Converter core
  input wire logic conv_start,
  input wire logic [3:0] conv_pos_port,
  input wire logic [3:0] conv_pos_pin,
  input wire logic [3:0] conv_neg_port,
  input wire logic [3:0] conv_neg_pin,
  input wire logic [2:0] conv_reference,
  input wire logic [2:0] conv_gain,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  // Results
  input wire logic result_valid,
  input wire logic [11:0] result_data,
  input wire logic result_single
);
  import asq_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // Access phase waits exactly one cycle, then completes once
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_complete;
    pready ##1 !pready;
  endsequence
  a_apb_wait: assert property (s_access |=> s_complete)
    else $error("APB answer timing wrong");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("Slave error without ready");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("Start longer than one cycle");
  // Selection only moves together with a start, so the core sees one set
  a_sel_held: assert property (!conv_start |-> $stable({conv_pos_port, conv_pos_pin,
    conv_neg_port, conv_neg_pin, conv_reference, conv_gain}))
    else $error("Selection changed without start");
  a_neg_pin_gnd: assert property (conv_neg_port == ASQ_PORT_GND |-> conv_neg_pin == 4'h0)
    else $error("Negative pin used with ground port");
  // Nonzero data only from a real conversion; errors give zero
  a_result_cause: assert property (result_valid && result_data != 12'h000 |-> $past(conv_done))
    else $error("Nonzero result without conversion");
  a_single_ended: assert property (result_valid && $past(conv_done) &&
    conv_neg_port == ASQ_PORT_GND |-> result_data == $past(conv_data))
    else $error("Single ended result wrong");
  a_diff_signed: assert property (result_valid && $past(conv_done) &&
    conv_neg_port != ASQ_PORT_GND |-> result_data == ($past(conv_data) ^ ASQ_DIFF_FLIP))
    else $error("Differential result wrong");
  // Two faulted entries in a row give results only two cycles apart
  a_result_pulse: assert property (result_valid |=> !result_valid)
    else $error("Result strobe too close");
endmodule : asq_scan_queue_monitor
`default_nettype wire

// File: dv/asq_scan_queue_test.sv
// Self-checking bench for the converter scan queue block
`timescale 1ns/1ps
`default_nettype none
module asq_scan_queue_test;
  import asq_pkg::*;
  typedef struct {
    logic [3:0] pp, pi, np, ni, ent;
    logic [2:0] rf, gn;
    logic sgl, err;
  } asq_exp_t;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, conv_start, conv_done;
  logic result_valid, result_single, drain;
  logic [11:0] paddr, conv_data, result_data, last_data;
  logic [31:0] pwdata, prdata;
  logic [3:0] conv_pos_port, conv_pos_pin, conv_neg_port, conv_neg_pin, result_entry, pa, pb;
  logic [2:0] conv_reference, conv_gain;
  logic [2:0] cfg_rf [2];
  logic [2:0] cfg_gn [2];
  asq_exp_t exp_q [$];
  logic [64:0] rd_q [$];
  int n_fail, samples_checked, cycles, cnt;
  asq_scan_queue u_asq_scan_queue (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_pos_port(conv_pos_port), .conv_pos_pin(conv_pos_pin),
    .conv_neg_port(conv_neg_port), .conv_neg_pin(conv_neg_pin),
    .conv_reference(conv_reference), .conv_gain(conv_gain), .conv_done(conv_done),
    .conv_data(conv_data), .result_valid(result_valid), .result_data(result_data),
    .result_entry(result_entry), .result_single(result_single)
  );
  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard, far above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      results();
    end
  end
  task results();
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task chk_rd(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      n_fail++;
      $display("ERROR %0t read %h expected %h", $time, got, want);
    end
  endtask : chk_rd
  task chk_res(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      n_fail++;
      $display("ERROR %0t result %h expected %h", $time, got, want);
    end
  endtask : chk_res
  ////////////////////////////////////////////////////////////////////////////
  // APB master: hold the request until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] want, input logic [31:0] msk,
    input logic err);
    rd_q.push_back({err, msk, want});
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] sel(logic c, logic [3:0] pp, pi, np, ni);
    return {15'h0000, c, pp, pi, np, ni};
  endfunction : sel
  function automatic logic [11:0] scan_a(int n);
    return {ASQ_SCAN_PAGE, 4'(n), 2'b00};
  endfunction : scan_a
  // Note one expected conversion; ground port hides the negative pin
  task automatic push(input logic c, input logic [3:0] pp, pi, np, ni, ent,
    input logic s, er);
    asq_exp_t x;
    x.pp = pp;
    x.pi = pi;
    x.np = np;
    x.ni = (np == ASQ_PORT_GND) ? 4'h0 : ni;
    x.rf = cfg_rf[c];
    x.gn = cfg_gn[c];
    x.ent = ent;
    x.sgl = s;
    x.err = er;
    exp_q.push_back(x);
  endtask : push
  task wait_idle();
    while (exp_q.size() != 0) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////
  // Read data against the oldest read note
  always @(posedge mclk)
  begin : rdchk
    logic [64:0] n;
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() != 0)
    begin
      n = rd_q.pop_front();
      chk_rd(prdata & n[63:32], n[31:0]);
      chk_rd({31'h0, pslverr}, {31'h0, n[64]});
    end
  end
  // Core stand-in with a slow, varying answer; checks selections and results
  always @(posedge mclk)
  begin : core
    asq_exp_t r;
    logic [11:0] want;
    conv_done <= 1'b0;
    if (result_valid === 1'b1 && !drain)
    begin
      r = exp_q.pop_front();
      want = r.err ? 12'h000 : (r.np == ASQ_PORT_GND) ? last_data : last_data ^ ASQ_DIFF_FLIP;
      chk_res({20'h0, result_data}, {20'h0, want});
      chk_res({31'h0, result_single}, {31'h0, r.sgl});
      if (!r.sgl) chk_res({28'h0, result_entry}, {28'h0, r.ent});
    end
    if (conv_start === 1'b1)
    begin
      r = exp_q[0];
      chk_res({conv_pos_port, conv_pos_pin, conv_neg_port, conv_neg_pin}, {r.pp, r.pi, r.np, r.ni});
      chk_res({conv_reference, conv_gain}, {r.rf, r.gn});
      cnt <= 4 + ($urandom % 4);
    end
    else if (cnt == 1)
    begin
      last_data = 12'($urandom);
      conv_data <= last_data;
      conv_done <= 1'b1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    conv_done = 1'b0;
    conv_data = 12'h000;
    drain = 1'b0;
    cnt = 0;
    cycles = 0;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(32'h1d7b));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(ASQ_OFS_CTRL, 32'h0, 32'hffffffff, 1'b0);
    rd(ASQ_OFS_STATUS, 32'h0, 32'hffffffff, 1'b0);
    rd(ASQ_OFS_MASK_WORK, 32'h0, 32'hffffffff, 1'b0);
    rd(ASQ_OFS_CFG0, 32'h10, 32'hffffffff, 1'b0);
    rd(12'h3fc, 32'h0, 32'hffffffff, 1'b1);
    // Every reference and gain code, one beyond the last reference
    for (int r = 0; r < 6; r++)
    begin
      apb(1'b1, ASQ_OFS_CFG0, r | ((r % 5) << 4));
      rd(ASQ_OFS_CFG0, (r > 4 ? 0 : r) | ((r % 5) << 4), 32'h77, 1'b0);
    end
    apb(1'b1, ASQ_OFS_CFG0, 32'h42); // 4x gain, core clock assumed within its limit
    apb(1'b1, ASQ_OFS_CFG1, 32'h04);
    cfg_rf[0] = ASQ_REF_EXT2;
    cfg_gn[0] = ASQ_GAIN_4X;
    cfg_rf[1] = ASQ_REF_VDD_BUF;
    cfg_gn[1] = ASQ_GAIN_HALF;
    apb(1'b1, ASQ_OFS_BUS_ALLOC, 32'h03);
    pa = 4'($urandom);
    pb = 4'($urandom);
    apb(1'b1, scan_a(0), sel(1'b0, ASQ_PORT_GPIO_A, pa, ASQ_PORT_GND, pb));
    apb(1'b1, scan_a(1), sel(1'b1, ASQ_PORT_GPIO_A, {pb[2:0], 1'b0}, ASQ_PORT_GPIO_A, {pa[2:0], 1'b1}));
    apb(1'b1, scan_a(3), sel(1'b0, ASQ_PORT_GPIO_A, 4'h4, ASQ_PORT_GPIO_A, 4'h6));
    apb(1'b1, scan_a(7), sel(1'b0, 4'h9, pa, ASQ_PORT_GND, 4'h0));
    apb(1'b1, ASQ_OFS_CTRL, 32'h1);
    // Dropped: selections are locked while enabled
    apb(1'b1, scan_a(0), sel(1'b1, ASQ_PORT_SUPPLY, 4'h0, 4'h0, 4'h0));
    // Scan of 0, 1 and 7 with a mask change in mid-scan
    apb(1'b1, ASQ_OFS_MASK_REQ, 32'h83);
    // Pending must be clear again before the mask is rewritten mid-scan
    rd(ASQ_OFS_STATUS, 32'h0, 32'h1, 1'b0);
    push(1'b0, ASQ_PORT_GPIO_A, pa, ASQ_PORT_GND, pb, 4'h0, 1'b0, 1'b0);
    push(1'b1, ASQ_PORT_GPIO_A, {pb[2:0], 1'b0}, ASQ_PORT_GPIO_A, {pa[2:0], 1'b1}, 4'h1, 1'b0, 1'b0);
    push(1'b0, 4'h9, pa, ASQ_PORT_GND, 4'h0, 4'h7, 1'b0, 1'b1);
    apb(1'b1, ASQ_OFS_CTRL, 32'h11);
    apb(1'b1, ASQ_OFS_MASK_REQ, 32'h8);
    rd(ASQ_OFS_STATUS, 32'h3, 32'h3, 1'b0);
    rd(ASQ_OFS_MASK_WORK, 32'h83, 32'hffffffff, 1'b0);
    wait_idle();
    rd(ASQ_OFS_STATUS, 32'h4, 32'h7, 1'b0);
    rd(ASQ_OFS_MASK_WORK, 32'h8, 32'hffffffff, 1'b0);
    apb(1'b1, ASQ_OFS_STATUS, 32'h4);
    rd(ASQ_OFS_STATUS, 32'h0, 32'hc, 1'b0);
    // Continuous repeat of entry 3, a polarity fault, then stop
    repeat (12) push(1'b0, ASQ_PORT_GPIO_A, 4'h4, ASQ_PORT_GPIO_A, 4'h6, 4'h3, 1'b0, 1'b1);
    apb(1'b1, ASQ_OFS_CTRL, 32'h3);
    while (exp_q.size() > 8) @(posedge mclk);
    apb(1'b1, ASQ_OFS_CTRL, 32'h1);
    drain = 1'b1;
    repeat (20) @(posedge mclk);
    exp_q.delete();
    drain = 1'b0;
    rd(ASQ_OFS_STATUS, 32'h8, 32'ha, 1'b0);
    // Single queue on the second configuration set
    apb(1'b1, ASQ_OFS_CTRL, 32'h0);
    apb(1'b1, ASQ_OFS_SINGLE, sel(1'b1, ASQ_PORT_GPIO_A, pb, ASQ_PORT_GND, pa));
    apb(1'b1, ASQ_OFS_CTRL, 32'h1);
    push(1'b1, ASQ_PORT_GPIO_A, pb, ASQ_PORT_GND, pa, 4'h0, 1'b1, 1'b0);
    apb(1'b1, ASQ_OFS_CTRL, 32'h21);
    wait_idle();
    results();
  end
endmodule : asq_scan_queue_test
bind asq_scan_queue asq_scan_queue_monitor u_asq_scan_queue_monitor (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .conv_start(conv_start), .conv_pos_port(conv_pos_port),
  .conv_pos_pin(conv_pos_pin), .conv_neg_port(conv_neg_port), .conv_neg_pin(conv_neg_pin),
  .conv_reference(conv_reference), .conv_gain(conv_gain), .conv_done(conv_done),
  .conv_data(conv_data), .result_valid(result_valid), .result_data(result_data),
  .result_single(result_single)
);
`default_nettype wire
